//--- core/pmcp_guard.sv
// Access guard for program memory, EEPROM, ID and configuration bytes.
// Assumes memory answers reads combinationally on i_mem_rdata for o_mem.addr; one request per three cycles.
//
// How it works
// - Boot region is the first 2 Kbytes from address zero.
// - Four further regions, three on the small variant, start 000800h, 002000h, 004000h, 006000h; end 007FFFh, or 005FFFh on the small variant.
// - Each region has external-access, table-write and cross-read inhibits.
// - External-access inhibit only gates requests from outside the device.
// - Table-write inhibit at zero blocks CPU table writes to that region.
// - Cross-read inhibit at zero still allows reads from code inside region.
// - Cross-read inhibit at zero returns zeros to reads from other regions.
// - Protection bits only go from one to zero by writes.
// - Only reset or external chip or block erase sets protection bits back to one.
// - CPU table access reaches program memory, configuration and device ID.
// - EEPROM read-inhibit refuses external EEPROM reads and writes.
// - EEPROM write-inhibit refuses CPU and external EEPROM writes.
// - CPU EEPROM access ignores the external EEPROM read-inhibit.
// - Config write-inhibit is set only externally and protects config bytes.
// - Eight ID bytes at 200000h-200007h stay readable under protection.
// - Protection bits live in configuration bytes 300008h to 30000Dh.
// - Debug enabled when debug configuration bit is zero.
// - Debug reserves two pins, 2 stack levels, 512 and 10 bytes.
`timescale 1ns/10ps
module pmcp_guard (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   input wire logic i_small_variant,
   input wire logic i_debug_cfg,
   input wire pmcp_pkg::pmcp_req_type i_req,
   input wire logic [7:0] i_mem_rdata,
   output pmcp_pkg::pmcp_resp_type o_resp,
   output pmcp_pkg::pmcp_mem_cmd_type o_mem,
   output pmcp_pkg::pmcp_prot_type o_prot,
   output logic o_debug_en,
   output logic o_debug_pins_reserved,
   output logic [1:0] o_debug_stack_levels,
   output logic [21:0] o_debug_prog_base
);
   typedef struct packed {
      pmcp_pkg::pmcp_state_type st;
      pmcp_pkg::pmcp_req_type req;
      pmcp_pkg::pmcp_prot_type prot;
      pmcp_pkg::pmcp_resp_type resp;
      pmcp_pkg::pmcp_mem_cmd_type mem;
      logic debug_en;
   } pmcp_guard_state_type;

   pmcp_guard_state_type cur;
   pmcp_guard_state_type next_cur;

   // Region decode
   // boot and block region decode
   function automatic pmcp_pkg::pmcp_region_type region_of(input logic [21:0] a, input logic small_part);
      region_of = pmcp_pkg::REG_NONE;
      if (a < pmcp_pkg::BLK0_BASE) begin
         region_of = pmcp_pkg::REG_BOOT;
      end else if (a < pmcp_pkg::BLK1_BASE) begin
         region_of = pmcp_pkg::REG_B0;
      end else if (a < pmcp_pkg::BLK2_BASE) begin
         region_of = pmcp_pkg::REG_B1;
      end else if (a < pmcp_pkg::BLK3_BASE) begin
         region_of = pmcp_pkg::REG_B2;
      end else if (a <= pmcp_pkg::BLK3_LAST && !small_part) begin
         region_of = pmcp_pkg::REG_B3;
      end
   endfunction

   // Active-low inhibit bit of one region from one pair of bytes
   function automatic logic inhibit_of(input pmcp_pkg::pmcp_region_type r, input logic [7:0] lo,
                                       input logic [7:0] hi, input int hi_bit);
      inhibit_of = 1'b0;
      case (r)
         pmcp_pkg::REG_BOOT: inhibit_of = !hi[hi_bit];
         pmcp_pkg::REG_B0: inhibit_of = !lo[0];
         pmcp_pkg::REG_B1: inhibit_of = !lo[1];
         pmcp_pkg::REG_B2: inhibit_of = !lo[2];
         pmcp_pkg::REG_B3: inhibit_of = !lo[pmcp_pkg::REGION_MSB];
         default: inhibit_of = 1'b0;
      endcase
   endfunction

   function automatic logic in_range(input logic [21:0] a, input logic [21:0] lo, input logic [21:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // Read of a protection byte, unimplemented bits as zero
   function automatic logic [7:0] cfg_read(input logic [21:0] a, input pmcp_pkg::pmcp_prot_type p,
                                           output logic hit);
      hit = 1'b1;
      cfg_read = pmcp_pkg::ZERO_BYTE;
      if (a == pmcp_pkg::CFG5L_ADDR) begin
         cfg_read = p.cfg5l;
      end else if (a == pmcp_pkg::CFG5H_ADDR) begin
         cfg_read = p.cfg5h;
      end else if (a == pmcp_pkg::CFG6L_ADDR) begin
         cfg_read = p.cfg6l;
      end else if (a == pmcp_pkg::CFG6H_ADDR) begin
         cfg_read = p.cfg6h;
      end else if (a == pmcp_pkg::CFG7L_ADDR) begin
         cfg_read = p.cfg7l;
      end else if (a == pmcp_pkg::CFG7H_ADDR) begin
         cfg_read = p.cfg7h;
      end else begin
         hit = 1'b0;
      end
   endfunction

   // Write: only clears allowed, masked to implemented bits
   // one to zero only
   function automatic logic [7:0] clear_only(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] m);
      clear_only = old & (wd | ~m);
   endfunction

   always_comb begin
      pmcp_pkg::pmcp_region_type tgt_reg;
      pmcp_pkg::pmcp_region_type src_reg;
      logic is_prog;
      logic is_id;
      logic is_cfg;
      logic is_devid;
      logic cfg_hit;
      logic [7:0] cfg_val;
      logic ext_inh;
      logic wr_inh;
      logic xrd_inh;
      logic ee_ext_inh;
      logic ee_wr_inh;
      logic cfg_wr_inh;
      logic ok;
      logic [7:0] rd;
      next_cur = cur;
      next_cur.resp.done = 1'b0;
      next_cur.mem.mem_wr = 1'b0;
      next_cur.mem.ee_wr = 1'b0;
      next_cur.mem.ee_rd = 1'b0;
      next_cur.mem.erase_all = 1'b0;
      ok = 1'b0;
      rd = pmcp_pkg::ZERO_BYTE;
      tgt_reg = region_of(cur.req.addr, i_small_variant);
      src_reg = region_of(cur.req.instr_addr, i_small_variant);
      is_prog = (tgt_reg != pmcp_pkg::REG_NONE);
      is_id = in_range(cur.req.addr, pmcp_pkg::ID_FIRST, pmcp_pkg::ID_LAST);
      is_cfg = in_range(cur.req.addr, pmcp_pkg::CFG_FIRST, pmcp_pkg::CFG_LAST);
      is_devid = in_range(cur.req.addr, pmcp_pkg::DEVID_FIRST, pmcp_pkg::DEVID_LAST);
      cfg_val = cfg_read(cur.req.addr, cur.prot, cfg_hit);
      ext_inh = inhibit_of(tgt_reg, cur.prot.cfg5l, cur.prot.cfg5h, pmcp_pkg::BOOT_BIT);
      wr_inh = inhibit_of(tgt_reg, cur.prot.cfg6l, cur.prot.cfg6h, pmcp_pkg::BOOT_BIT);
      xrd_inh = inhibit_of(tgt_reg, cur.prot.cfg7l, cur.prot.cfg7h, pmcp_pkg::BOOT_BIT);
      ee_ext_inh = !cur.prot.cfg5h[pmcp_pkg::EE_BIT];
      ee_wr_inh = !cur.prot.cfg6h[pmcp_pkg::EE_BIT];
      cfg_wr_inh = !cur.prot.cfg6h[pmcp_pkg::CFG_BIT];
      next_cur.debug_en = !i_debug_cfg;
      case (cur.st)
         pmcp_pkg::ST_IDLE: begin
            if (i_req.valid) begin
               next_cur.req = i_req;
               // Memory addressed during the busy cycle
               next_cur.mem.addr = i_req.addr;
               next_cur.mem.wdata = i_req.wdata;
               next_cur.st = pmcp_pkg::ST_BUSY;
            end
         end
         pmcp_pkg::ST_BUSY: begin
            next_cur.st = pmcp_pkg::ST_DONE;
            next_cur.mem.addr = cur.req.addr;
            next_cur.mem.wdata = cur.req.wdata;
            if (cur.req.target == pmcp_pkg::TGT_EEPROM) begin
               if (cur.req.op == pmcp_pkg::OP_READ) begin
                  ok = !(cur.req.external && ee_ext_inh);
                  rd = ok ? i_mem_rdata : pmcp_pkg::ZERO_BYTE;
                  next_cur.mem.ee_rd = ok;
               end else if (cur.req.op == pmcp_pkg::OP_WRITE) begin
                  ok = !ee_wr_inh && !(cur.req.external && ee_ext_inh);
                  next_cur.mem.ee_wr = ok;
               end
            end else if (cur.req.op == pmcp_pkg::OP_CHIP_ERASE || cur.req.op == pmcp_pkg::OP_BLOCK_ERASE) begin
               // erase only from outside restores ones
               if (cur.req.external) begin
                  ok = 1'b1;
                  next_cur.mem.erase_all = 1'b1;
                  next_cur.prot.cfg5l = pmcp_pkg::ERASED_BYTE & pmcp_pkg::LOW_MASK;
                  next_cur.prot.cfg5h = pmcp_pkg::ERASED_BYTE & pmcp_pkg::MASK5H;
                  next_cur.prot.cfg6l = pmcp_pkg::ERASED_BYTE & pmcp_pkg::LOW_MASK;
                  next_cur.prot.cfg6h = pmcp_pkg::ERASED_BYTE & pmcp_pkg::MASK6H;
                  next_cur.prot.cfg7l = pmcp_pkg::ERASED_BYTE & pmcp_pkg::LOW_MASK;
                  next_cur.prot.cfg7h = pmcp_pkg::ERASED_BYTE & pmcp_pkg::MASK7H;
               end
            end else if (cur.req.op == pmcp_pkg::OP_READ) begin
               if (is_prog) begin
                  // external inhibit only for outside requests
                  // CPU table read of program memory
                  if (cur.req.external) begin
                     ok = !ext_inh;
                  end else begin
                     ok = !xrd_inh || (src_reg == tgt_reg);
                  end
                  rd = ok ? i_mem_rdata : pmcp_pkg::ZERO_BYTE;
               end else if (is_id || is_devid) begin
                  ok = 1'b1;
                  rd = i_mem_rdata;
               end else if (is_cfg) begin
                  ok = 1'b1;
                  rd = cfg_hit ? cfg_val : i_mem_rdata;
               end else begin
                  rd = pmcp_pkg::ZERO_BYTE;
               end
            end else if (cur.req.op == pmcp_pkg::OP_WRITE) begin
               if (is_prog) begin
                  if (cur.req.external) begin
                     ok = !ext_inh;
                  end else begin
                     ok = !wr_inh;
                  end
                  next_cur.mem.mem_wr = ok;
               end else if (is_id) begin
                  ok = 1'b1;
                  next_cur.mem.mem_wr = 1'b1;
               end else if (is_cfg && !cfg_wr_inh) begin
                  // config bytes protected; config inhibit external only
                  ok = 1'b1;
                  if (cur.req.addr == pmcp_pkg::CFG5L_ADDR) begin
                     next_cur.prot.cfg5l = clear_only(cur.prot.cfg5l, cur.req.wdata, pmcp_pkg::LOW_MASK);
                  end else if (cur.req.addr == pmcp_pkg::CFG5H_ADDR) begin
                     next_cur.prot.cfg5h = clear_only(cur.prot.cfg5h, cur.req.wdata, pmcp_pkg::MASK5H);
                  end else if (cur.req.addr == pmcp_pkg::CFG6L_ADDR) begin
                     next_cur.prot.cfg6l = clear_only(cur.prot.cfg6l, cur.req.wdata, pmcp_pkg::LOW_MASK);
                  end else if (cur.req.addr == pmcp_pkg::CFG6H_ADDR) begin
                     next_cur.prot.cfg6h = clear_only(cur.prot.cfg6h,
                        cur.req.external ? cur.req.wdata : (cur.req.wdata | (8'h01 << pmcp_pkg::CFG_BIT)),
                        pmcp_pkg::MASK6H);
                  end else if (cur.req.addr == pmcp_pkg::CFG7L_ADDR) begin
                     next_cur.prot.cfg7l = clear_only(cur.prot.cfg7l, cur.req.wdata, pmcp_pkg::LOW_MASK);
                  end else if (cur.req.addr == pmcp_pkg::CFG7H_ADDR) begin
                     next_cur.prot.cfg7h = clear_only(cur.prot.cfg7h, cur.req.wdata, pmcp_pkg::MASK7H);
                  end else begin
                     next_cur.mem.mem_wr = 1'b1;
                  end
               end
            end
            next_cur.resp.granted = ok;
            next_cur.resp.rdata = rd;
            next_cur.resp.done = 1'b1;
         end
         pmcp_pkg::ST_DONE: begin
            next_cur.st = pmcp_pkg::ST_IDLE;
         end
         default: begin
            next_cur.st = pmcp_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cur.st <= pmcp_pkg::ST_IDLE;
         cur.req <= '0;
         cur.prot.cfg5l <= pmcp_pkg::ERASED_BYTE & pmcp_pkg::LOW_MASK;
         cur.prot.cfg5h <= pmcp_pkg::ERASED_BYTE & pmcp_pkg::MASK5H;
         cur.prot.cfg6l <= pmcp_pkg::ERASED_BYTE & pmcp_pkg::LOW_MASK;
         cur.prot.cfg6h <= pmcp_pkg::ERASED_BYTE & pmcp_pkg::MASK6H;
         cur.prot.cfg7l <= pmcp_pkg::ERASED_BYTE & pmcp_pkg::LOW_MASK;
         cur.prot.cfg7h <= pmcp_pkg::ERASED_BYTE & pmcp_pkg::MASK7H;
         cur.resp <= '0;
         cur.mem <= '0;
         cur.debug_en <= 1'b0;
      end else if (i_ce) begin
         cur <= next_cur;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_debug_pins_reserved <= 1'b0;
         o_debug_stack_levels <= 2'h0;
         o_debug_prog_base <= 22'h000000;
      end else if (i_ce) begin
         o_debug_pins_reserved <= next_cur.debug_en;
         o_debug_stack_levels <= next_cur.debug_en ? 2'(pmcp_pkg::DBG_STACK_LEVELS) : 2'h0;
         o_debug_prog_base <= next_cur.debug_en ?
            (i_small_variant ? pmcp_pkg::SMALL_LAST - 22'(pmcp_pkg::DBG_PROG_BYTES) + 22'h000001
                             : pmcp_pkg::DBG_PROG_BASE) : 22'h000000;
      end
   end

   assign o_resp = cur.resp;
   assign o_mem = cur.mem;
   assign o_prot = cur.prot;
   assign o_debug_en = cur.debug_en;
endmodule

//--- core/pmcp_pkg.sv
// Package for the program memory code protection block.
// Assumes a byte-addressed 22-bit table address space and 8-bit configuration bytes.
package pmcp_pkg;
   localparam int ADDR_W = 22;
   localparam logic [21:0] BOOT_BASE = 22'h000000;
   localparam logic [21:0] BLK0_BASE = 22'h000800;
   localparam logic [21:0] BLK1_BASE = 22'h002000;
   localparam logic [21:0] BLK2_BASE = 22'h004000;
   localparam logic [21:0] BLK3_BASE = 22'h006000;
   localparam logic [21:0] BLK3_LAST = 22'h007FFF;
   localparam logic [21:0] ID_FIRST = 22'h200000;
   localparam logic [21:0] ID_LAST = 22'h200007;
   localparam logic [21:0] DEVID_FIRST = 22'h3FFFFE;
   localparam logic [21:0] DEVID_LAST = 22'h3FFFFF;
   localparam logic [21:0] CFG_FIRST = 22'h300000;
   localparam logic [21:0] CFG_LAST = 22'h30000D;
   localparam logic [21:0] CFG5L_ADDR = 22'h300008;
   localparam logic [21:0] CFG5H_ADDR = 22'h300009;
   localparam logic [21:0] CFG6L_ADDR = 22'h30000A;
   localparam logic [21:0] CFG6H_ADDR = 22'h30000B;
   localparam logic [21:0] CFG7L_ADDR = 22'h30000C;
   localparam logic [21:0] CFG7H_ADDR = 22'h30000D;
   // Field positions
   localparam int REGION_MSB = 3;
   localparam int EE_BIT = 7;
   localparam int BOOT_BIT = 6;
   localparam int CFG_BIT = 5;
   // Implemented bit masks per configuration byte
   localparam logic [7:0] LOW_MASK = 8'h0F;
   localparam logic [7:0] MASK5H = 8'hC0;
   localparam logic [7:0] MASK6H = 8'hE0;
   localparam logic [7:0] MASK7H = 8'h40;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // Debugger reservations
   localparam int DBG_STACK_LEVELS = 2;
   localparam int DBG_PROG_BYTES = 512;
   localparam int DBG_DATA_BYTES = 10;
   localparam logic [21:0] DBG_PROG_BASE = BLK3_LAST - 22'(DBG_PROG_BYTES) + 22'h000001;
   localparam logic [21:0] SMALL_LAST = BLK2_BASE + 22'h001FFF;

   typedef enum logic [2:0] {
      REG_BOOT = 3'h0,
      REG_B0 = 3'h1,
      REG_B1 = 3'h2,
      REG_B2 = 3'h3,
      REG_B3 = 3'h4,
      REG_NONE = 3'h7
   } pmcp_region_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_BUSY = 2'b01,
      ST_DONE = 2'b11
   } pmcp_state_type;

   typedef enum logic [1:0] {
      OP_READ = 2'h0,
      OP_WRITE = 2'h1,
      OP_BLOCK_ERASE = 2'h2,
      OP_CHIP_ERASE = 2'h3
   } pmcp_op_type;

   typedef enum logic [1:0] {
      TGT_PROG = 2'h0,
      TGT_EEPROM = 2'h1
   } pmcp_target_type;

   typedef struct packed {
      logic valid;
      logic external;
      pmcp_op_type op;
      pmcp_target_type target;
      logic [21:0] addr;
      logic [21:0] instr_addr;
      logic [7:0] wdata;
   } pmcp_req_type;

   typedef struct packed {
      logic done;
      logic granted;
      logic [7:0] rdata;
   } pmcp_resp_type;

   typedef struct packed {
      logic [7:0] cfg5l;
      logic [7:0] cfg5h;
      logic [7:0] cfg6l;
      logic [7:0] cfg6h;
      logic [7:0] cfg7l;
      logic [7:0] cfg7h;
   } pmcp_prot_type;

   typedef struct packed {
      logic mem_wr;
      logic ee_wr;
      logic ee_rd;
      logic erase_all;
      logic [21:0] addr;
      logic [7:0] wdata;
   } pmcp_mem_cmd_type;
endpackage

//--- tb/pmcp_guard_asserts.sv
// Checker for the protection guard ports.
// Assumes i_ce stays high and one request per three cycles.
`timescale 1ns/10ps
module pmcp_guard_asserts (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_ce,
   input wire logic i_small_variant,
   input wire logic i_debug_cfg,
   input wire pmcp_pkg::pmcp_req_type i_req,
   input wire logic [7:0] i_mem_rdata,
   input wire pmcp_pkg::pmcp_resp_type o_resp,
   input wire pmcp_pkg::pmcp_mem_cmd_type o_mem,
   input wire pmcp_pkg::pmcp_prot_type o_prot,
   input wire logic o_debug_en,
   input wire logic o_debug_pins_reserved,
   input wire logic [1:0] o_debug_stack_levels,
   input wire logic [21:0] o_debug_prog_base
);
   logic [1:0] phase;
   pmcp_pkg::pmcp_req_type held;
   int rg;
   int ri;
   function automatic int reg_of(input logic [21:0] a);
      if (a < pmcp_pkg::BLK0_BASE) return 0;
      if (a < pmcp_pkg::BLK1_BASE) return 1;
      if (a < pmcp_pkg::BLK2_BASE) return 2;
      if (a < pmcp_pkg::BLK3_BASE) return 3;
      if (a <= pmcp_pkg::BLK3_LAST) return 4;
      return 7;
   endfunction
   function automatic logic pick(input logic [7:0] lo, input logic [7:0] hi, input int r);
      return (r == 0) ? hi[6] : lo[r-1];
   endfunction
   // Tracks the request in flight
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         phase <= 2'd0;
         held <= '0;
      end else if (i_ce) begin
         if (phase == 2'd0 && i_req.valid) begin
            phase <= 2'd1;
            held <= i_req;
         end else if (phase != 2'd0) begin
            phase <= (phase == 2'd1) ? 2'd2 : 2'd0;
         end
      end
   end
   assign rg = reg_of(held.addr);
   assign ri = reg_of(held.instr_addr);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   AST_DONE_TIME: assert property (o_resp.done == (phase == 2'd2))
      else $error("done not two edges after take");
   AST_STROBE_DONE: assert property ((o_mem.mem_wr || o_mem.ee_wr || o_mem.ee_rd || o_mem.erase_all) |-> o_resp.done)
      else $error("memory strobe outside done cycle");
   AST_EXT_INHIBIT: assert property (o_resp.done && held.external && held.target == pmcp_pkg::TGT_PROG
      && held.op inside {pmcp_pkg::OP_READ, pmcp_pkg::OP_WRITE} && rg != 7
      && !pick(o_prot.cfg5l, o_prot.cfg5h, rg) |-> !o_resp.granted)
      else $error("external access granted to inhibited region");
   AST_CROSS_ZERO: assert property (o_resp.done && !held.external && held.op == pmcp_pkg::OP_READ
      && held.target == pmcp_pkg::TGT_PROG && rg != 7 && ri != rg
      && !pick(o_prot.cfg7l, o_prot.cfg7h, rg) |-> o_resp.rdata == 8'h00)
      else $error("cross-region read not zero");
   AST_TABLE_WRITE: assert property (o_mem.mem_wr && !held.external && rg != 7 |-> pick(o_prot.cfg6l, o_prot.cfg6h, rg))
      else $error("table write into inhibited region");
   AST_EE_WRITE: assert property (o_mem.ee_wr |-> o_prot.cfg6h[7] && (!held.external || o_prot.cfg5h[7]))
      else $error("eeprom write while inhibited");
   AST_ERASE_EXT: assert property (o_mem.erase_all |-> held.external)
      else $error("erase from cpu");
   AST_BITS_RISE: assert property ((o_prot & ~$past(o_prot)) != '0 |->
      held.external && held.op inside {pmcp_pkg::OP_BLOCK_ERASE, pmcp_pkg::OP_CHIP_ERASE})
      else $error("protection bit set without erase");
   AST_ID_OPEN: assert property (o_resp.done && held.target == pmcp_pkg::TGT_PROG
      && held.addr inside {[pmcp_pkg::ID_FIRST:pmcp_pkg::ID_LAST]}
      && held.op inside {pmcp_pkg::OP_READ, pmcp_pkg::OP_WRITE} |-> o_resp.granted)
      else $error("id byte access refused");
   AST_DEBUG_EN: assert property ($past(i_arst_n) && $past(i_ce) |-> o_debug_en == !$past(i_debug_cfg))
      else $error("debug enable not following config bit");
   AST_DEBUG_RES: assert property (o_debug_en && $past(o_debug_en) |->
      o_debug_stack_levels == 2'd2 && o_debug_pins_reserved)
      else $error("debug reservations missing");
endmodule
bind pmcp_guard pmcp_guard_asserts u_pmcp_guard_asserts (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
   .i_small_variant(i_small_variant), .i_debug_cfg(i_debug_cfg), .i_req(i_req), .i_mem_rdata(i_mem_rdata),
   .o_resp(o_resp), .o_mem(o_mem), .o_prot(o_prot), .o_debug_en(o_debug_en),
   .o_debug_pins_reserved(o_debug_pins_reserved), .o_debug_stack_levels(o_debug_stack_levels),
   .o_debug_prog_base(o_debug_prog_base));

//--- tb/pmcp_mem_model.sv
// Byte memory model behind the guard.
// Assumes reads follow the guard's address combinationally.
`timescale 1ns/10ps
module pmcp_mem_model (
   input wire logic i_clk,
   input wire pmcp_pkg::pmcp_mem_cmd_type i_mem,
   output logic [7:0] o_rdata
);
   logic [7:0] cells [0:255];
   initial begin
      for (int i = 0; i < 256; i++) begin
         cells[i] = 8'(i) ^ 8'h5A;
      end
   end
   always @(posedge i_clk) begin
      if (i_mem.mem_wr) begin
         cells[i_mem.addr[7:0]] <= i_mem.wdata;
      end
   end
   assign o_rdata = cells[i_mem.addr[7:0]];
endmodule

//--- tb/pmcp_guard_bench.sv
// Testbench for the protection guard.
// Assumes the memory model and the bound checker.
`timescale 1ns/10ps
module pmcp_guard_bench;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic ce = 1'b1;
   logic small_var = 1'b0;
   logic dbg_cfg = 1'b1;
   pmcp_pkg::pmcp_req_type req = '0;
   pmcp_pkg::pmcp_resp_type resp;
   pmcp_pkg::pmcp_mem_cmd_type mem_cmd;
   pmcp_pkg::pmcp_prot_type prot;
   logic [7:0] mem_rdata;
   logic dbg_en, dbg_pins, g, wr, ew, er;
   logic [1:0] dbg_lvl;
   logic [21:0] dbg_base;
   logic [7:0] rd;
   int mismatches = 0;
   int total_checks = 0;
   localparam logic [21:0] ADR [8] = '{22'h000000, 22'h0007FF, 22'h000800, 22'h001FFF,
      22'h002000, 22'h004000, 22'h005FFF, 22'h007FFF};
   localparam logic [47:0] PROT_RST = {8'h0F, 8'hC0, 8'h0F, 8'hE0, 8'h0F, 8'h40};
   always #50 i_clk = ~i_clk;
   pmcp_guard u_pmcp_guard (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(ce), .i_small_variant(small_var),
      .i_debug_cfg(dbg_cfg), .i_req(req), .i_mem_rdata(mem_rdata), .o_resp(resp), .o_mem(mem_cmd),
      .o_prot(prot), .o_debug_en(dbg_en), .o_debug_pins_reserved(dbg_pins),
      .o_debug_stack_levels(dbg_lvl), .o_debug_prog_base(dbg_base));
   pmcp_mem_model u_pmcp_mem_model (.i_clk(i_clk), .i_mem(mem_cmd), .o_rdata(mem_rdata));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic acc(input logic ext, input logic [1:0] op, input logic tg, input logic [21:0] a,
      input logic [21:0] ia, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge i_clk);
      #1;
      req = '{1'b1, ext, pmcp_pkg::pmcp_op_type'(op), pmcp_pkg::pmcp_target_type'({1'b0, tg}), a, ia, wd};
      @(posedge i_clk);
      #1;
      req.valid = 1'b0;
      while (resp.done !== 1'b1 && n < 8) begin
         @(posedge i_clk);
         #1;
         n++;
      end
      chk(resp.done, 1'b1, "no completion");
      {g, rd, wr, ew, er} = {resp.granted, resp.rdata, mem_cmd.mem_wr, mem_cmd.ee_wr, mem_cmd.erase_all};
   endtask
   task automatic cr(input logic [21:0] a, input logic [21:0] ia);
      acc(1'b0, 2'd0, 1'b0, a, ia, 8'h00);
   endtask
   task automatic xw(input logic [21:0] a, input logic [7:0] d);
      acc(1'b1, 2'd1, 1'b0, a, 22'h0, d);
   endtask
   task automatic note(input string name);
      $display("test %s finished at %0t", name, $time);
   endtask
   initial begin
      #(3000 * 100);
      mismatches++;
      $display("[FAIL] %0t watchdog expired", $time);
      give_verdict();
   end
   initial begin
      repeat (5) @(posedge i_clk);
      #1 i_arst_n = 1'b1;
      chk(prot, PROT_RST, "reset protection bytes");
      chk({dbg_en, dbg_pins, dbg_lvl, dbg_base}, 0, "debug outputs idle");
      foreach (ADR[i]) begin
         cr(ADR[i], 22'h0);
         chk({g, rd}, {1'b1, ADR[i][7:0] ^ 8'h5A}, "open region read");
      end
      note("region map");
      xw(pmcp_pkg::CFG7L_ADDR, 8'h0E);
      xw(pmcp_pkg::CFG7L_ADDR, 8'h0F);
      chk(prot.cfg7l, 8'h0E, "bit set back by write");
      cr(22'h000800, 22'h000100);
      chk({g, rd}, {1'b0, 8'h00}, "cross read from boot");
      cr(22'h000800, 22'h000900);
      chk({g, rd}, {1'b1, 8'h5A}, "read from same region");
      xw(pmcp_pkg::CFG5L_ADDR, 8'h0D);
      acc(1'b1, 2'd0, 1'b0, 22'h002000, 22'h0, 8'h00);
      chk(g, 1'b0, "external read inhibited");
      cr(22'h002000, 22'h0);
      chk({g, rd}, {1'b1, 8'h5A}, "cpu ignores external inhibit");
      xw(pmcp_pkg::CFG6L_ADDR, 8'h0B);
      acc(1'b0, 2'd1, 1'b0, 22'h004010, 22'h0, 8'hC3);
      chk({g, wr}, 2'b00, "table write inhibited");
      acc(1'b0, 2'd1, 1'b0, 22'h006010, 22'h0, 8'hC3);
      chk({g, wr}, 2'b11, "table write open");
      cr(22'h006010, 22'h006000);
      chk(rd, 8'hC3, "written byte read back");
      note("program protection");
      xw(pmcp_pkg::CFG5H_ADDR, 8'h40);
      acc(1'b1, 2'd0, 1'b1, 22'h000010, 22'h0, 8'h00);
      chk(g, 1'b0, "external eeprom read");
      acc(1'b1, 2'd1, 1'b1, 22'h000010, 22'h0, 8'h11);
      chk({g, ew}, 2'b00, "external eeprom write");
      acc(1'b0, 2'd0, 1'b1, 22'h000010, 22'h0, 8'h00);
      chk(g, 1'b1, "cpu eeprom read");
      acc(1'b0, 2'd1, 1'b1, 22'h000010, 22'h0, 8'h22);
      chk({g, ew}, 2'b11, "cpu eeprom write");
      xw(pmcp_pkg::CFG6H_ADDR, 8'h60);
      acc(1'b0, 2'd1, 1'b1, 22'h000010, 22'h0, 8'h33);
      chk({g, ew}, 2'b00, "cpu eeprom write inhibited");
      note("eeprom");
      acc(1'b1, 2'd0, 1'b0, pmcp_pkg::ID_FIRST, 22'h0, 8'h00);
      chk(g, 1'b1, "id byte read");
      acc(1'b0, 2'd1, 1'b0, pmcp_pkg::ID_LAST, 22'h0, 8'h44);
      chk({g, wr}, 2'b11, "id byte write");
      acc(1'b0, 2'd1, 1'b0, pmcp_pkg::CFG6H_ADDR, 22'h0, 8'h40);
      chk(prot.cfg6h, 8'h60, "cpu cannot clear config lock");
      xw(pmcp_pkg::CFG6H_ADDR, 8'h40);
      xw(pmcp_pkg::CFG5L_ADDR, 8'h00);
      chk({prot.cfg6h, prot.cfg5l}, 16'h400D, "config bytes locked");
      note("id and config");
      acc(1'b0, 2'd3, 1'b0, 22'h0, 22'h0, 8'h00);
      chk({er, prot}, {1'b0, 8'h0D, 8'h40, 8'h0B, 8'h40, 8'h0E, 8'h40}, "cpu erase refused");
      acc(1'b1, 2'd3, 1'b0, 22'h0, 22'h0, 8'h00);
      chk({er, prot}, {1'b1, PROT_RST}, "chip erase restores");
      xw(pmcp_pkg::CFG7L_ADDR, 8'h0C);
      acc(1'b1, 2'd2, 1'b0, 22'h000800, 22'h0, 8'h00);
      chk(prot, PROT_RST, "block erase restores");
      note("erase");
      small_var = 1'b1;
      cr(22'h006010, 22'h006000);
      chk(rd, 8'h00, "absent region reads zero");
      dbg_cfg = 1'b0;
      repeat (3) @(posedge i_clk);
      #1;
      chk({dbg_en, dbg_pins, dbg_lvl, dbg_base}, {4'b1110, 22'h006000 - 22'd512}, "debug reserved");
      note("variant and debug");
      give_verdict();
   end
endmodule
